// ===== core/lvclk_defs.svh
// Offsets, field positions, reset values, serial port framing and delay step of the output clock register bank
`ifndef LVCLK_DEFS_SVH
`define LVCLK_DEFS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define LVCLK_OFS_PHASE 13'h0016
`define LVCLK_OFS_DELAY 13'h0017
`define LVCLK_OFS_RSVD 13'h0018
`define LVCLK_OFS_PAT1_LO 13'h0019
`define LVCLK_OFS_PAT1_HI 13'h001A
`define LVCLK_OFS_PAT2_LO 13'h001B
`define LVCLK_OFS_PAT2_HI 13'h001C

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define LVCLK_PHASE_INV_BIT 4
`define LVCLK_PHASE_SEL_HI 1
`define LVCLK_PHASE_SEL_LO 0
`define LVCLK_DELAY_EN_BIT 7
`define LVCLK_DELAY_CODE_HI 4
`define LVCLK_DELAY_CODE_LO 0

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define LVCLK_RST_PHASE 8'h00
`define LVCLK_RST_DELAY 8'h00
`define LVCLK_RST_RSVD 8'h04
`define LVCLK_RST_PAT 8'h00

// ----------------------------------------------------------------
// Serial port framing and delay step
// ----------------------------------------------------------------
`define LVCLK_INSTR_BITS 5'd16
`define LVCLK_FRAME_BITS 5'd24
`define LVCLK_DELAY_STEP_PS 100

`endif

// ===== core/lvclk_pkg.sv
// Types shared by the output clock register bank
package lvclk_pkg;

   typedef enum logic [1:0] {
      LVCLK_PH_PLUS90,
      LVCLK_PH_ZERO,
      LVCLK_PH_MINUS90
   } lvclk_phase_e;

   typedef struct packed {
      logic clk_invert;
      lvclk_phase_e phase;
      logic delay_en;
      logic [5:0] delay_steps;
      logic [15:0] pattern_one;
      logic [15:0] pattern_two;
   } lvclk_cfg_s;

endpackage : lvclk_pkg

// ===== core/lvclk_regs.sv
// Serial-port register bank for output data clock alignment and user patterns
// Operation
// (R1) Phase bit 4 inverts output data clock
// (R2) Phase bits 1:0 select coarse clock phase
// (R3) Delay bit 7 enables fine clock delay
// (R4) Delay code picks 100 ps step amount
// (R5) Pattern one held as two byte registers
// (R6) Pattern two held as two byte registers
// (R7) Software keeps reserved bits at reset values
`timescale 1ns/1ps
`include "lvclk_defs.svh"

module lvclk_regs #(
   parameter int SYNC_STAGES = 2
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic spi_csb_n,
   input wire logic spi_sclk,
   input wire logic sdio_i,
   output logic sdio_o,
   output logic sdio_oe,
   output lvclk_pkg::lvclk_cfg_s cfg
);

   // Edge detect timing assumes exactly two stages ahead of it
   if (SYNC_STAGES != 2) begin : g_bad_sync
      $error("lvclk_regs: only two synchroniser stages are supported");
   end

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   logic [1:0] csb_sync_r;
   logic [1:0] sclk_sync_r;
   logic [1:0] sdio_sync_r;
   logic sclk_prev_r;

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         csb_sync_r <= 2'h3;
         sclk_sync_r <= 2'h0;
         sdio_sync_r <= 2'h0;
         sclk_prev_r <= 1'b0;
      end else begin
         csb_sync_r <= {csb_sync_r[0], spi_csb_n};
         sclk_sync_r <= {sclk_sync_r[0], spi_sclk};
         sdio_sync_r <= {sdio_sync_r[0], sdio_i};
         sclk_prev_r <= sclk_sync_r[1];
      end
   end

   wire logic csb_n_s = csb_sync_r[1];
   wire logic sclk_rise = sclk_sync_r[1] & ~sclk_prev_r & ~csb_n_s;
   wire logic sdio_s = sdio_sync_r[1];

   // ----------------------------------------------------------------
   // Frame shifter
   // ----------------------------------------------------------------
   // Frame: R/W, two length bits (single byte only), 13 address bits, 8 data bits
   logic [4:0] bit_cnt_r;
   logic [4:0] bit_cnt_nxt;
   logic [22:0] shift_r;
   logic [22:0] shift_nxt;
   logic [7:0] tx_r;
   logic [7:0] tx_nxt;
   logic oe_r;
   logic oe_nxt;

   wire logic [23:0] frame = {shift_r, sdio_s};
   wire logic is_read = shift_r[14];
   wire logic [12:0] addr = shift_r[12:0];
   wire logic [12:0] wr_addr = frame[20:8];
   wire logic instr_done = sclk_rise && (bit_cnt_r == `LVCLK_INSTR_BITS - 5'd1);
   wire logic wr_strobe = sclk_rise && (bit_cnt_r == `LVCLK_FRAME_BITS - 5'd1) && !frame[23];
   wire logic [7:0] wr_data = frame[7:0];

   // ----------------------------------------------------------------
   // Register storage
   // ----------------------------------------------------------------
   logic [7:0] phase_r;
   logic [7:0] delay_r;
   logic [7:0] rsvd_r;
   logic [7:0] pat1_lo_r;
   logic [7:0] pat1_hi_r;
   logic [7:0] pat2_lo_r;
   logic [7:0] pat2_hi_r;

   function automatic logic [7:0] rd_mux(input logic [12:0] a, input logic [7:0] ph,
                                         input logic [7:0] dl, input logic [7:0] rs,
                                         input logic [7:0] p1l, input logic [7:0] p1h,
                                         input logic [7:0] p2l, input logic [7:0] p2h);
      logic [7:0] v;
      v = 8'h00;
      unique case (a)
         `LVCLK_OFS_PHASE: v = ph;
         `LVCLK_OFS_DELAY: v = dl;
         `LVCLK_OFS_RSVD: v = rs;
         `LVCLK_OFS_PAT1_LO: v = p1l;
         `LVCLK_OFS_PAT1_HI: v = p1h;
         `LVCLK_OFS_PAT2_LO: v = p2l;
         `LVCLK_OFS_PAT2_HI: v = p2h;
         default: v = 8'h00;
      endcase
      return v;
   endfunction : rd_mux

   // Address of a completing instruction includes the bit arriving now
   wire logic [12:0] rd_addr = {addr[11:0], sdio_s};
   wire logic [7:0] rd_data = rd_mux(rd_addr, phase_r, delay_r, rsvd_r,
                                     pat1_lo_r, pat1_hi_r, pat2_lo_r, pat2_hi_r);

   always_comb begin
      bit_cnt_nxt = bit_cnt_r;
      shift_nxt = shift_r;
      tx_nxt = tx_r;
      oe_nxt = oe_r;
      if (csb_n_s) begin
         bit_cnt_nxt = 5'd0;
         oe_nxt = 1'b0;
      end else if (sclk_rise) begin
         shift_nxt = frame[22:0];
         bit_cnt_nxt = (bit_cnt_r == `LVCLK_FRAME_BITS - 5'd1) ? 5'd0 : bit_cnt_r + 5'd1;
         if (instr_done && is_read) begin
            tx_nxt = rd_data;
            oe_nxt = 1'b1;
         end else if (oe_r) begin
            tx_nxt = {tx_r[6:0], 1'b0};
            oe_nxt = (bit_cnt_r != `LVCLK_FRAME_BITS - 5'd1);
         end
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         bit_cnt_r <= 5'd0;
         shift_r <= 23'h000000;
         tx_r <= 8'h00;
         oe_r <= 1'b0;
      end else begin
         bit_cnt_r <= bit_cnt_nxt;
         shift_r <= shift_nxt;
         tx_r <= tx_nxt;
         oe_r <= oe_nxt;
      end
   end

   assign sdio_o = tx_r[7];
   assign sdio_oe = oe_r;

   // ----------------------------------------------------------------
   // Write decode
   // ----------------------------------------------------------------
   // A write lands only on the last bit of a whole frame; aborted frames never write
   wire logic we_phase = wr_strobe && (wr_addr == `LVCLK_OFS_PHASE);
   wire logic we_delay = wr_strobe && (wr_addr == `LVCLK_OFS_DELAY);
   wire logic we_rsvd = wr_strobe && (wr_addr == `LVCLK_OFS_RSVD);
   wire logic we_pat1_lo = wr_strobe && (wr_addr == `LVCLK_OFS_PAT1_LO);
   wire logic we_pat1_hi = wr_strobe && (wr_addr == `LVCLK_OFS_PAT1_HI);
   wire logic we_pat2_lo = wr_strobe && (wr_addr == `LVCLK_OFS_PAT2_LO);
   wire logic we_pat2_hi = wr_strobe && (wr_addr == `LVCLK_OFS_PAT2_HI);

   // ----------------------------------------------------------------
   // Register writes
   // ----------------------------------------------------------------
   // Reserved bits are stored as written; software is trusted to keep them
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         phase_r <= `LVCLK_RST_PHASE;
         delay_r <= `LVCLK_RST_DELAY;
         rsvd_r <= `LVCLK_RST_RSVD; // R7
      end else begin
         if (we_phase) phase_r <= wr_data;
         if (we_delay) delay_r <= wr_data;
         if (we_rsvd) rsvd_r <= wr_data;
      end
   end

   // Pattern bytes are independent; a half-written word shows until both land
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         pat1_lo_r <= `LVCLK_RST_PAT;
         pat1_hi_r <= `LVCLK_RST_PAT;
         pat2_lo_r <= `LVCLK_RST_PAT;
         pat2_hi_r <= `LVCLK_RST_PAT;
      end else begin
         if (we_pat1_lo) pat1_lo_r <= wr_data; // R5
         if (we_pat1_hi) pat1_hi_r <= wr_data; // R5
         if (we_pat2_lo) pat2_lo_r <= wr_data; // R6
         if (we_pat2_hi) pat2_hi_r <= wr_data; // R6
      end
   end

   // ----------------------------------------------------------------
   // Configuration outputs
   // ----------------------------------------------------------------
   wire logic [1:0] phase_code = phase_r[`LVCLK_PHASE_SEL_HI:`LVCLK_PHASE_SEL_LO];
   wire logic [4:0] delay_code = delay_r[`LVCLK_DELAY_CODE_HI:`LVCLK_DELAY_CODE_LO];
   wire logic delay_on = delay_r[`LVCLK_DELAY_EN_BIT];
   // Codes 01 and 10 both give zero phase
   wire lvclk_pkg::lvclk_phase_e phase_sel =
      (phase_code == 2'h0) ? lvclk_pkg::LVCLK_PH_PLUS90 :
      (phase_code == 2'h3) ? lvclk_pkg::LVCLK_PH_MINUS90 : lvclk_pkg::LVCLK_PH_ZERO; // R2
   // Steps of 100 ps: code 0 gives one step, zero when the delay is off
   wire logic [5:0] steps = delay_on ? ({1'b0, delay_code} + 6'd1) : 6'd0; // R3 R4

   lvclk_pkg::lvclk_cfg_s cfg_nxt;
   lvclk_pkg::lvclk_cfg_s cfg_r;

   assign cfg_nxt = '{
      clk_invert: phase_r[`LVCLK_PHASE_INV_BIT], // R1
      phase: phase_sel, // R2
      delay_en: delay_on, // R3
      delay_steps: steps, // R4
      pattern_one: {pat1_hi_r, pat1_lo_r}, // R5
      pattern_two: {pat2_hi_r, pat2_lo_r} // R6
   };

   // Registered so the clock shaper never sees decode glitches; costs one clk of latency
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         cfg_r <= '0;
      end else begin
         cfg_r <= cfg_nxt;
      end
   end

   assign cfg = cfg_r;

endmodule : lvclk_regs

// ===== tb/lvclk_regs_assertions.sv
// Port checker for the output clock register bank
`timescale 1ns/1ps
module lvclk_regs_assertions #(
   parameter int SYNC_STAGES = 2
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic spi_csb_n,
   input wire logic spi_sclk,
   input wire logic sdio_o,
   input wire logic sdio_oe,
   input wire lvclk_pkg::lvclk_cfg_s cfg
);
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   property p_rst;
      disable iff (1'b0) sys_rst |-> cfg == '0 && !sdio_oe;
   endproperty
   property p_phase;
      2'(cfg.phase) != 2'h3;
   endproperty
   property p_off;
      !cfg.delay_en |-> cfg.delay_steps == 6'h00;
   endproperty
   property p_on;
      cfg.delay_en |-> cfg.delay_steps inside {[6'h01:6'h20]};
   endproperty
   // Config may only move inside a frame, well after chip select fell
   property p_quiet;
      $changed(cfg) |-> !spi_csb_n && !$past(spi_csb_n, 3);
   endproperty
   property p_oe_go;
      $rose(sdio_oe) |-> spi_sclk && !spi_csb_n;
   endproperty
   property p_oe_end;
      $rose(spi_csb_n) |-> ##[1:6] !sdio_oe;
   endproperty
   a_rst: assert property (p_rst) else $error("config not at default in reset");
   a_phase: assert property (p_phase) else $error("illegal phase code");
   a_off: assert property (p_off) else $error("delay steps while disabled");
   a_on: assert property (p_on) else $error("delay steps out of range");
   a_quiet: assert property (p_quiet) else $error("config moved outside frame");
   a_oe_go: assert property (p_oe_go) else $error("drive began off frame");
   a_oe_end: assert property (p_oe_end) else $error("drive held after frame");
   c_inv: cover property (cfg.clk_invert);
   c_read: cover property ($rose(sdio_oe));
   c_dly: cover property (cfg.delay_en && cfg.delay_steps == 6'h20);
endmodule : lvclk_regs_assertions
bind lvclk_regs lvclk_regs_assertions #(.SYNC_STAGES(SYNC_STAGES)) u_chk (.clk(clk),
   .sys_rst(sys_rst), .spi_csb_n(spi_csb_n), .spi_sclk(spi_sclk), .sdio_o(sdio_o),
   .sdio_oe(sdio_oe), .cfg(cfg));

// ===== tb/lvclk_host_model.sv
// Serial control port host that frames register accesses
`timescale 1ns/1ps
module lvclk_host_model (
   input wire logic clk,
   output logic csb_n,
   output logic sclk,
   output logic sdio,
   input wire logic sdio_o
);
   initial begin
      csb_n = 1'b1;
      sclk = 1'b0;
      sdio = 1'b0;
   end
   // Short nbits aborts the frame by raising chip select early
   task automatic xfer(input logic rd, input logic [12:0] adr, input logic [7:0] wd,
                       input int nbits, output logic [7:0] rdat);
      logic [23:0] fr;
      fr = {rd, 2'b00, adr, wd};
      @(negedge clk) csb_n = 1'b0;
      repeat (4) @(negedge clk);
      for (int i = 0; i < nbits; i++) begin
         // Released line toggles so a stale level cannot pass for data
         sdio = (rd && i > 15) ? ~sdio : fr[23-i];
         repeat (5) @(negedge clk);
         if (i > 15)
            rdat[23-i] = sdio_o;
         sclk = 1'b1;
         repeat (5) @(negedge clk);
         sclk = 1'b0;
      end
      repeat (4) @(negedge clk);
      csb_n = 1'b1;
      sdio = ~sdio;
      repeat (6) @(negedge clk);
   endtask : xfer
endmodule : lvclk_host_model

// ===== tb/test_lvclk_regs.sv
// Self-checking bench for the output clock register bank
`timescale 1ns/1ps
module test_lvclk_regs;
   // Clock starts high so reset lands ahead of the first rising edge
   logic clk = 1'b1;
   logic sys_rst;
   logic spi_csb_n, spi_sclk, host_sdio, sdio_o, sdio_oe;
   wire logic sdio_i;
   lvclk_pkg::lvclk_cfg_s cfg;
   int err_total = 0;
   int samples_checked = 0;
   logic [7:0] rd_q;
   always #25 clk = ~clk;
   assign sdio_i = sdio_oe ? sdio_o : host_sdio;
   lvclk_regs u_dut (.clk(clk), .sys_rst(sys_rst), .spi_csb_n(spi_csb_n),
      .spi_sclk(spi_sclk), .sdio_i(sdio_i), .sdio_o(sdio_o), .sdio_oe(sdio_oe), .cfg(cfg));
   lvclk_host_model u_host (.clk(clk), .csb_n(spi_csb_n), .sclk(spi_sclk),
      .sdio(host_sdio), .sdio_o(sdio_o));
   task automatic chk(input logic [47:0] got, input logic [47:0] exp);
      samples_checked++;
      if (got !== exp) begin
         err_total++;
         $display("BAD t=%0t got %h want %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [12:0] a, input logic [7:0] d);
      u_host.xfer(1'b0, a, d, 24, rd_q);
   endtask : wr
   task automatic rd_chk(input logic [12:0] a, input logic [7:0] e);
      u_host.xfer(1'b1, a, 8'h00, 24, rd_q);
      chk(rd_q, e);
   endtask : rd_chk
   task automatic do_reset;
      @(negedge clk) sys_rst = 1'b1;
      repeat (6) @(negedge clk);
      sys_rst = 1'b0;
      repeat (4) @(negedge clk);
   endtask : do_reset
   task automatic t_reset;
      logic [7:0] rv [7] = '{8'h00, 8'h00, 8'h04, 8'h00, 8'h00, 8'h00, 8'h00};
      chk(cfg, '0);
      for (int i = 0; i < 7; i++)
         rd_chk(13'h0016 + 13'(i), rv[i]);
      rd_chk(13'h0015, 8'h00);
   endtask : t_reset
   task automatic t_phase;
      for (int c = 0; c < 4; c++) begin
         wr(13'h0016, {3'h0, c[0], 2'h0, c[1:0]});
         chk(cfg.clk_invert, c[0]);
         chk(cfg.phase, (c == 3) ? lvclk_pkg::LVCLK_PH_MINUS90 : (c == 0 ? lvclk_pkg::LVCLK_PH_PLUS90 : lvclk_pkg::LVCLK_PH_ZERO));
         rd_chk(13'h0016, {3'h0, c[0], 2'h0, c[1:0]});
      end
   endtask : t_phase
   task automatic t_delay;
      logic [7:0] cd [4] = '{8'h80, 8'h81, 8'h9F, 8'h05};
      for (int i = 0; i < 4; i++) begin
         wr(13'h0017, cd[i]);
         chk(cfg.delay_en, cd[i][7]);
         chk(cfg.delay_steps, cd[i][7] ? cd[i][4:0] + 6'h01 : 6'h00);
      end
   endtask : t_delay
   task automatic t_pattern;
      wr(13'h0019, 8'hA5);
      wr(13'h001A, 8'h3C);
      wr(13'h001B, 8'h5A);
      wr(13'h001C, 8'hC3);
      chk(cfg.pattern_one, 16'h3CA5);
      chk(cfg.pattern_two, 16'hC35A);
      wr(13'h001A, 8'hFF);
      chk(cfg.pattern_one, 16'hFFA5);
      rd_chk(13'h001C, 8'hC3);
   endtask : t_pattern
   task automatic t_refuse;
      u_host.xfer(1'b0, 13'h0019, 8'h11, 20, rd_q);
      wr(13'h0015, 8'hEE);
      wr(13'h0018, 8'h04);
      chk(cfg.pattern_one, 16'hFFA5);
      rd_chk(13'h0015, 8'h00);
      rd_chk(13'h0018, 8'h04);
   endtask : t_refuse
   task automatic end_of_test;
      $display("errors %0d checks %0d", err_total, samples_checked);
      if (err_total == 0 && samples_checked > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : end_of_test
   initial begin
      do_reset();
      t_reset();
      t_phase();
      t_delay();
      t_pattern();
      t_refuse();
      do_reset();
      t_reset();
      end_of_test();
   end
   // Fixed-length frames cannot hang; this only guards a stuck run
   initial begin
      #2ms;
      $display("BAD t=%0t run limit reached", $time);
      err_total++;
      end_of_test();
   end
endmodule : test_lvclk_regs
